//--- design/dics_pkg.sv
// Constants for the serial configuration setup block
package dics_pkg;
    // ============================================================
    // Frame layout
    localparam int          FRAME_BYTES      = 4;
    localparam logic [7:0]  CMD_WRITE        = 8'h02;
    localparam logic [7:0]  CMD_READ         = 8'h82;
    localparam logic [7:0]  CMD_WRITE_ADC    = 8'h03;
    localparam int          CMD_READ_BIT     = 7;
    localparam logic [7:0]  CRC_POLY         = 8'h07;
    localparam logic [7:0]  CRC_INIT         = 8'h00;
    // ============================================================
    // Register addresses (arbitrary choice)
    localparam logic [7:0]  ADDR_CONFIG      = 8'h00;
    localparam logic [7:0]  ADDR_ADC_CFG     = 8'h01;
    localparam logic [7:0]  ADDR_ADC_DATA    = 8'h02;
    // ============================================================
    // CONFIG field positions
    localparam int          CFG_CRC_EN_BIT   = 0;
    localparam int          CFG_SO_DIS_BIT   = 1;
    localparam logic [15:0] CONFIG_RESET     = 16'h0003;
    // ADC_CFG field positions
    localparam int          ADC_ADC_BUFFER_POWERDOWN_BIT   = 0;
    localparam logic [15:0] ADC_CFG_RESET    = 16'h0001;
endpackage

//--- design/dics_crc8.sv
// Byte-wide CRC-8 update step
module dics_crc8 (
    // Inputs
    input  wire logic [7:0] crc_in,
    input  wire logic [7:0] data_in,
    // Outputs
    output logic      [7:0] crc_out
);
    always_comb begin
        logic [7:0] c;
        c = crc_in ^ data_in;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ dics_pkg::CRC_POLY) : (c << 1);
        end
        crc_out = c;
    end
endmodule

//--- design/dics_top.sv
// Serial configuration front end with frame CRC and output gating
// Functional notes
// - CRC checking enabled after reset
// - CRC byte required while checking active
// - Serial output disabled after reset
// - Reads return data only when output enabled
// - Writing zero to disable bit enables output
// - Zero buffer powerdown bit powers ADC buffer
module dics_top (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // Byte stream from host
    input  wire logic        frame_start_in,
    input  wire logic        byte_valid_in,
    input  wire logic [7:0]  byte_in,
    // ADC result
    input  wire logic [15:0] adc_result_in,
    // Outputs
    output logic             so_valid_out,
    output logic [15:0]      so_data_out,
    output logic             serial_out_enable_out,
    output logic             adc_buffer_on_out,
    output logic             crc_error_out,
    output logic             cmd_done_out
);
    // ============================================================
    // Byte position within a frame
    typedef enum logic [1:0] {
        POS_CMD,
        POS_HI,
        POS_LO,
        POS_CRC
    } dics_pos_e;

    // ============================================================
    // State
    typedef struct packed {
        dics_pos_e   pos;
        logic [7:0]  cmd;
        logic [7:0]  hi;
        logic [7:0]  lo;
        logic [7:0]  crc;
        logic [15:0] config_reg;
        logic [15:0] adc_cfg;
        logic        so_valid;
        logic [15:0] so_data;
        logic        crc_err;
        logic        done;
        logic        so_en;
        logic        buf_on;
    } dics_state_s;

    dics_state_s st_r;
    dics_state_s st_nxt;

    // ============================================================
    // Decode signals
    logic [7:0]  crc_next;
    logic        crc_on;
    logic        out_on;
    logic        take_byte;
    logic        at_cmd;
    logic        at_hi;
    logic        at_lo;
    logic        at_crc;
    logic        frame_end;
    logic        crc_good;
    logic        frame_ok;
    logic        frame_bad;
    logic        is_wr_config;
    logic        is_wr_adc;
    logic        is_read;
    logic        sel_config;
    logic        sel_adc_cfg;
    logic        sel_adc_data;
    logic [15:0] wdata;
    logic [15:0] rdata;
    dics_pos_e   pos_nxt;

    // ============================================================
    // Running CRC over the bytes of the frame
    dics_crc8 u_crc (
        .crc_in  (st_r.crc),
        .data_in (byte_in),
        .crc_out (crc_next)
    );

    // ============================================================
    // Configuration in force
    always_comb begin
        crc_on    = st_r.config_reg[dics_pkg::CFG_CRC_EN_BIT];
        out_on    = ~st_r.config_reg[dics_pkg::CFG_SO_DIS_BIT];
        take_byte = byte_valid_in & ~frame_start_in;
    end

    // ============================================================
    // Byte position and frame end
    always_comb begin
        at_cmd  = 1'b0;
        at_hi   = 1'b0;
        at_lo   = 1'b0;
        at_crc  = 1'b0;
        pos_nxt = st_r.pos;
        unique case (st_r.pos)
            POS_CMD: begin
                at_cmd  = 1'b1;
                pos_nxt = POS_HI;
            end
            POS_HI: begin
                at_hi   = 1'b1;
                pos_nxt = POS_LO;
            end
            POS_LO: begin
                at_lo = 1'b1;
                if (crc_on) begin
                    pos_nxt = POS_CRC;
                end else begin
                    pos_nxt = POS_CMD;
                end
            end
            POS_CRC: begin
                at_crc  = 1'b1;
                pos_nxt = POS_CMD;
            end
        endcase
        frame_end = take_byte & (crc_on ? at_crc : at_lo);
    end

    // ============================================================
    // Frame check
    always_comb begin
        crc_good  = ~crc_on | (crc_next == 8'h00);
        frame_ok  = frame_end & crc_good;
        frame_bad = frame_end & ~crc_good;
        wdata     = crc_on ? {st_r.hi, st_r.lo} : {st_r.hi, byte_in};
    end

    // ============================================================
    // Command decode
    always_comb begin
        is_wr_config = (st_r.cmd == dics_pkg::CMD_WRITE);
        is_wr_adc    = (st_r.cmd == dics_pkg::CMD_WRITE_ADC);
        is_read      = st_r.cmd[dics_pkg::CMD_READ_BIT];
        sel_config   = (st_r.cmd[6:0] == dics_pkg::ADDR_CONFIG[6:0]);
        sel_adc_cfg  = (st_r.cmd[6:0] == dics_pkg::ADDR_ADC_CFG[6:0]);
        sel_adc_data = (st_r.cmd[6:0] == dics_pkg::ADDR_ADC_DATA[6:0]);
    end

    // ============================================================
    // Read data select
    always_comb begin
        rdata = 16'h0000;
        if (sel_config) begin
            rdata = st_r.config_reg;
        end else if (sel_adc_cfg) begin
            rdata = st_r.adc_cfg;
        end else if (sel_adc_data) begin
            rdata = adc_result_in;
        end
    end

    // ============================================================
    // Next state
    always_comb begin
        st_nxt          = st_r;
        st_nxt.so_valid = 1'b0;
        st_nxt.crc_err  = frame_bad;
        st_nxt.done     = frame_ok;
        if (frame_start_in) begin
            st_nxt.pos = POS_CMD;
            st_nxt.crc = dics_pkg::CRC_INIT;
        end else if (take_byte) begin
            st_nxt.pos = pos_nxt;
            st_nxt.crc = crc_next;
            if (at_cmd) begin
                st_nxt.cmd = byte_in;
            end
            if (at_hi) begin
                st_nxt.hi = byte_in;
            end
            if (at_lo) begin
                st_nxt.lo = byte_in;
            end
            if (frame_end) begin
                st_nxt.crc = dics_pkg::CRC_INIT;
            end
        end
        if (frame_ok && is_wr_config) begin
            st_nxt.config_reg = wdata;
        end
        if (frame_ok && is_wr_adc) begin
            st_nxt.adc_cfg = wdata;
        end
        if (frame_ok && is_read && out_on) begin
            st_nxt.so_valid = 1'b1;
            st_nxt.so_data  = rdata;
        end
        st_nxt.so_en  = ~st_nxt.config_reg[dics_pkg::CFG_SO_DIS_BIT];
        st_nxt.buf_on = ~st_nxt.adc_cfg[dics_pkg::ADC_ADC_BUFFER_POWERDOWN_BIT];
    end

    // ============================================================
    // Registers
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_r            <= '0;
            st_r.pos        <= POS_CMD;
            st_r.crc        <= dics_pkg::CRC_INIT;
            st_r.config_reg <= dics_pkg::CONFIG_RESET;
            st_r.adc_cfg    <= dics_pkg::ADC_CFG_RESET;
            st_r.so_en      <= 1'b0;
            st_r.buf_on     <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ============================================================
    // Outputs
    always_comb begin
        so_valid_out          = st_r.so_valid;
        so_data_out           = st_r.so_data;
        serial_out_enable_out = st_r.so_en;
        adc_buffer_on_out     = st_r.buf_on;
        crc_error_out         = st_r.crc_err;
        cmd_done_out          = st_r.done;
    end
endmodule

//--- verification/dics_top_props.sv
// Port checker for the setup block
module dics_top_props (
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic byte_valid_in,
    input  wire logic so_valid_out,
    input  wire logic serial_out_enable_out,
    input  wire logic adc_buffer_on_out,
    input  wire logic crc_error_out,
    input  wire logic cmd_done_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // ============================================================
    // Properties
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    sequence s_answer;
        cmd_done_out || crc_error_out;
    endsequence
    a_reset_out_off: assert property ($fell(rst_in) |-> !serial_out_enable_out
        && !adc_buffer_on_out) else $error("output or buffer on after reset");
    a_read_gated: assert property (so_valid_out |-> serial_out_enable_out)
        else $error("read data while output disabled");
    a_bad_dropped: assert property (crc_error_out |-> !cmd_done_out && !so_valid_out)
        else $error("bad frame acted on");
    a_answer_after: assert property (s_answer |-> $past(byte_valid_in))
        else $error("answer without final byte");
    a_enable_write: assert property ($changed(serial_out_enable_out) |->
        cmd_done_out || $past(rst_in)) else $error("output enable moved without write");
    a_buffer_write: assert property ($changed(adc_buffer_on_out) |->
        cmd_done_out || $past(rst_in)) else $error("buffer moved without write");
endmodule

//--- verification/dics_host.sv
// Host model sending command frames
module dics_host (
    // Clock
    input  wire logic       clk_in,
    // Byte stream to the device
    output logic            frame_start_out,
    output logic            byte_valid_out,
    output logic [7:0]      byte_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        frame_start_out = 1'h0;
        byte_valid_out = 1'h0;
        byte_out = 8'h00;
    end
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] v;
        v = c ^ d;
        for (int i = 0; i < 8; i++) v = v[7] ? {v[6:0], 1'h0} ^ 8'h07 : {v[6:0], 1'h0};
        return v;
    endfunction
    // CRC byte appended while checking is on, as in the disable frame
    task automatic send(input logic [7:0] c, h, l, input logic crc_on, input logic [7:0] flip);
        send_raw(c, h, l, crc8(crc8(crc8(8'h00, c), h), l) ^ flip, crc_on ? 4 : 3);
    endtask
    // Literal frame of n bytes, returns at the edge after the last byte is taken
    task automatic send_raw(input logic [7:0] b0, b1, b2, b3, input int n);
        logic [7:0] b [4];
        b = '{b0, b1, b2, b3};
        @(negedge clk_in) frame_start_out = 1'h1;
        @(negedge clk_in) frame_start_out = 1'h0;
        for (int i = 0; i < n; i++) begin
            byte_valid_out = 1'h1;
            byte_out = b[i];
            @(negedge clk_in);
        end
        byte_valid_out = 1'h0;
        byte_out = ~byte_out;
    endtask
endmodule

//--- verification/tb_dics_top.sv
// Testbench for the setup block
module tb_dics_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_in = 1'h0;
    logic        rst_in = 1'h1;
    logic        fs, bv, so_v, ena, buf_on, err, done;
    logic [7:0]  bt;
    logic [15:0] so_d;
    logic [15:0] adc_res = 16'hA5C3;
    int          miscompares = 0;
    int          tests_run = 0;
    wire  logic [15:0] flags = {13'h0000, so_v, done, err};
    always #25 clk_in = ~clk_in;
    dics_host host (.clk_in(clk_in), .frame_start_out(fs), .byte_valid_out(bv), .byte_out(bt));
    dics_top dut (.clk_in(clk_in), .rst_in(rst_in), .frame_start_in(fs), .byte_valid_in(bv),
        .byte_in(bt), .adc_result_in(adc_res), .so_valid_out(so_v), .so_data_out(so_d),
        .serial_out_enable_out(ena), .adc_buffer_on_out(buf_on), .crc_error_out(err),
        .cmd_done_out(done));
    // ============================================================
    // Helpers and scenarios
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic fr(input logic [7:0] c, h, l, input logic crc_on, input logic [7:0] f);
        host.send(c, h, l, crc_on, f);
    endtask
    task automatic t_bad;
        chk({14'h0000, ena, buf_on}, 16'h0000);
        fr(8'h02, 8'h00, 8'h01, 1'h1, 8'h01);
        chk(flags, 16'h0001);
        fr(8'h80, 8'h00, 8'h00, 1'h1, 8'h00);
        chk(flags, 16'h0002);
        $display("t_bad end");
    endtask
    task automatic t_enable;
        fr(8'h02, 8'h00, 8'h01, 1'h1, 8'h00);
        chk({15'h0000, ena}, 16'h0001);
        fr(8'h80, 8'h00, 8'h00, 1'h1, 8'h00);
        chk({15'h0000, so_v}, 16'h0001);
        chk(so_d, 16'h0001);
        fr(8'h03, 8'h00, 8'h00, 1'h1, 8'h00);
        chk({15'h0000, buf_on}, 16'h0001);
        fr(8'h82, 8'h00, 8'h00, 1'h1, 8'h00);
        chk(so_d, 16'hA5C3);
        adc_res = 16'h3C5A;
        fr(8'h82, 8'h00, 8'h00, 1'h1, 8'h00);
        chk(so_d, 16'h3C5A);
        $display("t_enable end");
    endtask
    task automatic t_crc_off;
        fr(8'h02, 8'h00, 8'h00, 1'h1, 8'h00);
        fr(8'h80, 8'h00, 8'h00, 1'h0, 8'h00);
        chk({15'h0000, so_v}, 16'h0001);
        chk(so_d, 16'h0000);
        $display("t_crc_off end");
    endtask
    task automatic t_disable;
        @(negedge clk_in) rst_in = 1'h1;
        repeat (3) @(negedge clk_in);
        rst_in = 1'h0;
        chk({14'h0000, ena, buf_on}, 16'h0000);
        host.send_raw(8'h02, 8'h00, 8'h26, 8'h24, 4);
        chk(flags, 16'h0002);
        chk({15'h0000, ena}, 16'h0000);
        fr(8'h02, 8'h00, 8'h00, 1'h0, 8'h00);
        chk({15'h0000, ena}, 16'h0001);
        $display("t_disable end");
    endtask
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk_in);
        @(negedge clk_in) rst_in = 1'h0;
        t_bad;
        t_enable;
        t_crc_off;
        t_disable;
        print_verdict;
    end
    initial begin
        #20000;
        miscompares++;
        print_verdict;
    end
endmodule
bind dics_top dics_top_props u_props (.clk_in(clk_in), .rst_in(rst_in),
    .byte_valid_in(byte_valid_in), .so_valid_out(so_valid_out),
    .serial_out_enable_out(serial_out_enable_out), .adc_buffer_on_out(adc_buffer_on_out),
    .crc_error_out(crc_error_out), .cmd_done_out(cmd_done_out));
